// ===== common/psd_defs.vh
// Constants for the tuner synthesizer divider control block
`ifndef PSD_DEFS_VH
`define PSD_DEFS_VH
// Register addresses (bank 15)
`define PSD_ADDR_MODE 8'h10
`define PSD_ADDR_REF 8'h11
`define PSD_ADDR_UNLOCK 8'h12
`define PSD_ADDR_DATA 8'h13
// Reset values
`define PSD_REF_RESET 3'h7
`define PSD_MODE_RESET 3'h0
// Mode codes (low three bits of mode register)
`define PSD_MODE_OFF 3'h0
`define PSD_MODE_DIRECT 3'h1
`define PSD_MODE_SW_LOW 3'h2
`define PSD_MODE_SW_HIGH 3'h3
// Field positions
`define PSD_SWLSB_BIT 3
// Reference codes that disable
`define PSD_REF_DIS0 3'h6
`define PSD_REF_DIS1 3'h7
// Divider widths
`define PSD_PROG_W 12
`define PSD_SWAL_W 5
// Prescaler moduli
`define PSD_PRESC_HI 6'h21
`define PSD_PRESC_LO 6'h20
// System clock frequency
`define PSD_CLK_KHZ 250000
// Reference terminal counts in system clocks (scaled periods less one)
`define PSD_REF_TC0 10'h12b
`define PSD_REF_TC1 10'h063
`define PSD_REF_TC2 10'h03b
`define PSD_REF_TC3 10'h02f
`define PSD_REF_TC4 10'h017
`define PSD_REF_TC5 10'h00b
`endif

// ===== design/psd_ctrl.v
// Synthesizer divider control: registers, divider, comparator, pump
//
// Operation
// - Reference codes 110/111 halt the whole synthesizer.
// - When halted, inputs pulled low, division, reference and comparator stop, pump floats.
// - Mode 0000 only pulls both oscillator inputs low; the rest runs.
// - With inputs off the pump keeps running and normally drives low.
// - Any reset or clock stop loads 0111 into the reference register.
// - Halt keeps all settings unchanged.
// - Unlock bit undefined after resets, kept over clock stop; upper bits read zero.
// - Direct and low swallow modes divide the low-band input.
// - High swallow mode divides the high-band input.
// - Swallow N is 17 bits, LSB from mode bit 3, data register holds N>>1.
// - Reference codes 0-5 give 1,3,5,6.25,12.5,25 kHz; top bit reads zero.
// - Pump low when reference leads, high when divided leads, float when equal.
// - Unlock flag sets per reference cycle on up/down, clears on read.
// - Direct uses upper 12 bits; swallow adds low 5 bits as swallow counter.
`timescale 1ns/10ps
`default_nettype none
`include "psd_defs.vh"
module psd_ctrl
(
  // Clock and reset
  input wire sys_clk_in,
  input wire rstn_in,
  // Reset sources and power states
  input wire wdt_stack_reset_in,
  input wire clock_stop_in,
  input wire halt_in,
  // Peripheral register port
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_write_in,
  input wire reg_read_in,
  output reg [15:0] reg_rdata_out,
  // Oscillator inputs
  input wire low_band_osc_input_in,
  input wire high_band_osc_input_in,
  output wire low_band_pulldown_out,
  output wire high_band_pulldown_out,
  // Error outputs (tri-state)
  output reg error_output_a_out,
  output reg error_output_a_oe_out,
  output reg error_output_b_out,
  output reg error_output_b_oe_out,
  // Status
  output wire synth_enabled_out,
  output reg prescaler_high_out
);
  // ===========================================================
  // Registers
  reg [2:0] ref_sel;
  reg [3:0] mode_reg;
  reg [15:0] divider_value_register;
  reg [16:0] n_latched;
  reg unlock_ff;
  wire soft_rst = wdt_stack_reset_in | clock_stop_in;
  wire enabled = (ref_sel != `PSD_REF_DIS0) &&
                 (ref_sel != `PSD_REF_DIS1);
  wire [2:0] mode = mode_reg[2:0];
  wire swallow = (mode == `PSD_MODE_SW_LOW) ||
                 (mode == `PSD_MODE_SW_HIGH);
  wire wr_data = reg_write_in && (reg_addr_in == `PSD_ADDR_DATA);
  wire rd_unlock = reg_read_in && (reg_addr_in == `PSD_ADDR_UNLOCK);
  wire set_unlock;

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in || soft_rst)
      ref_sel <= `PSD_REF_RESET;
    else if (reg_write_in && reg_addr_in == `PSD_ADDR_REF && !halt_in)
      ref_sel <= reg_wdata_in[2:0];
  end

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      mode_reg <= {1'b0, `PSD_MODE_RESET};
      divider_value_register <= 16'h0000;
      n_latched <= 17'h00000;
    end
    else if (!halt_in)
    begin
      if (reg_write_in && reg_addr_in == `PSD_ADDR_MODE)
        mode_reg <= reg_wdata_in[3:0];
      if (wr_data)
      begin
        divider_value_register <= reg_wdata_in;
        // Flag travels into the counters with the data write
        n_latched <= {reg_wdata_in,
                      mode_reg[`PSD_SWLSB_BIT]};
      end
    end
  end

  // Unlock flag: set wins over the read clear. No reset: undefined
  // after reset pins, retained across clock stop.
  always @(posedge sys_clk_in)
  begin
    if (set_unlock)
      unlock_ff <= 1'b1;
    else if (rd_unlock)
      unlock_ff <= 1'b0;
  end

  always @*
  begin
    case (reg_addr_in)
      `PSD_ADDR_REF: reg_rdata_out = {13'h0000, ref_sel};
      `PSD_ADDR_MODE: reg_rdata_out = {12'h000, mode_reg};
      `PSD_ADDR_UNLOCK: reg_rdata_out = {15'h0000, unlock_ff};
      `PSD_ADDR_DATA: reg_rdata_out = divider_value_register;
      default: reg_rdata_out = 16'h0000;
    endcase
  end

  // ===========================================================
  // Input selection
  wire use_low = enabled && ((mode == `PSD_MODE_DIRECT) ||
                 (mode == `PSD_MODE_SW_LOW));
  wire use_high = enabled && (mode == `PSD_MODE_SW_HIGH);
  assign low_band_pulldown_out = !use_low;
  assign high_band_pulldown_out = !use_high;
  assign synth_enabled_out = enabled;

  reg [1:0] lo_s;
  reg [1:0] hi_s;
  reg vco_prev;
  always @(posedge sys_clk_in)
  begin
    lo_s <= {lo_s[0], low_band_osc_input_in};
    hi_s <= {hi_s[0], high_band_osc_input_in};
    vco_prev <= use_high ? hi_s[1] : (use_low ? lo_s[1] : 1'b0);
  end
  wire vco_now = use_high ? hi_s[1] : (use_low ? lo_s[1] : 1'b0);
  wire vco_edge = vco_now && !vco_prev;

  // ===========================================================
  // Divider: prescaler + swallow + programmable counter
  reg [5:0] presc;
  reg [4:0] swal;
  reg [11:0] prog;
  reg div_tick;
  wire [5:0] presc_mod = prescaler_high_out ? `PSD_PRESC_HI :
                         `PSD_PRESC_LO;
  always @(posedge sys_clk_in)
  begin
    div_tick <= 1'b0;
    if (!rstn_in || !enabled)
    begin
      presc <= 6'h00;
      swal <= 5'h00;
      prog <= 12'h000;
      prescaler_high_out <= 1'b0;
    end
    else if (vco_edge)
    begin
      if (!swallow)
      begin
        // Direct: upper 12 bits only
        if (prog <= 12'h001)
        begin
          prog <= n_latched[16:5];
          div_tick <= 1'b1;
        end
        else
          prog <= prog - 12'h001;
      end
      else if (presc + 6'h01 >= presc_mod)
      begin
        presc <= 6'h00;
        if (swal != 5'h00)
        begin
          swal <= swal - 5'h01;
          // Last swallow cycle ends: back to the smaller modulus
          if (swal == 5'h01)
            prescaler_high_out <= 1'b0;
        end
        if (prog <= 12'h001)
        begin
          prog <= n_latched[16:5];
          swal <= n_latched[4:0];
          // Larger modulus only while a swallow count is pending
          prescaler_high_out <= (n_latched[4:0] != 5'h00);
          div_tick <= 1'b1;
        end
        else
          prog <= prog - 12'h001;
      end
      else
        presc <= presc + 6'h01;
    end
  end

  // ===========================================================
  // Reference, comparator, pump
  wire ref_tick;
  psd_refgen u_ref
  (
    .sys_clk_in(sys_clk_in),
    .rstn_in(rstn_in),
    .run_in(enabled),
    .rate_in(ref_sel),
    .tick_out(ref_tick)
  );
  reg up_req;
  reg down_req;
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in || !enabled)
    begin
      up_req <= 1'b0;
      down_req <= 1'b0;
    end
    else if (ref_tick && !div_tick)
    begin
      up_req <= !down_req;
      down_req <= 1'b0;
    end
    else if (div_tick && !ref_tick)
    begin
      down_req <= !up_req;
      up_req <= 1'b0;
    end
    else if (ref_tick && div_tick)
    begin
      up_req <= 1'b0;
      down_req <= 1'b0;
    end
  end
  // Sampled once per reference cycle
  assign set_unlock = ref_tick && (up_req || down_req);

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in || !enabled)
    begin
      error_output_a_oe_out <= 1'b0;
      error_output_b_oe_out <= 1'b0;
      error_output_a_out <= 1'b0;
      error_output_b_out <= 1'b0;
    end
    else
    begin
      // Up request drives low, down drives high, neither floats
      error_output_a_oe_out <= up_req | down_req;
      error_output_b_oe_out <= up_req | down_req;
      error_output_a_out <= down_req;
      error_output_b_out <= down_req;
    end
  end
endmodule // psd_ctrl
`default_nettype wire

// ===== design/psd_refgen.v
// Reference divider: pulse once per reference period
`timescale 1ns/10ps
`default_nettype none
`include "psd_defs.vh"
module psd_refgen
(
  // Clock and reset
  input wire sys_clk_in,
  input wire rstn_in,
  // Control
  input wire run_in,
  input wire [2:0] rate_in,
  // Output
  output reg tick_out
);
  // Scaled periods; one tick every terminal count plus one clocks, so
  // every rate keeps the same ratio to the others
  function [9:0] terminal_count;
    input [2:0] code;
    begin
      case (code)
        3'h0: terminal_count = `PSD_REF_TC0;
        3'h1: terminal_count = `PSD_REF_TC1;
        3'h2: terminal_count = `PSD_REF_TC2;
        3'h3: terminal_count = `PSD_REF_TC3;
        3'h4: terminal_count = `PSD_REF_TC4;
        3'h5: terminal_count = `PSD_REF_TC5;
        default: terminal_count = 10'h000;
      endcase
    end
  endfunction
  reg [9:0] cnt;
  wire [9:0] limit = terminal_count(rate_in);
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in || !run_in)
    begin
      cnt <= 10'h000;
      tick_out <= 1'b0;
    end
    else if (cnt >= limit)
    begin
      cnt <= 10'h000;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt <= cnt + 10'h001;
      tick_out <= 1'b0;
    end
  end
endmodule // psd_refgen
`default_nettype wire

// ===== verification/psd_ctrl_chk.sv
// Port checker for the synthesizer divider control
`timescale 1ns/10ps
`default_nettype none
`include "psd_defs.vh"
module psd_ctrl_chk
(
  // Clock and reset
  input wire sys_clk_in,
  input wire rstn_in,
  // Inputs
  input wire wdt_stack_reset_in,
  input wire clock_stop_in,
  input wire halt_in,
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire reg_write_in,
  // Outputs
  input wire [15:0] reg_rdata_out,
  input wire low_band_pulldown_out,
  input wire high_band_pulldown_out,
  input wire error_output_a_oe_out,
  input wire error_output_b_oe_out,
  input wire synth_enabled_out
);
  wire rld = wdt_stack_reset_in || clock_stop_in;
  wire rwr = reg_write_in && !halt_in && reg_addr_in == `PSD_ADDR_REF;
  wire dis = reg_wdata_in[2:1] == 2'h3;
  wire msel = reg_addr_in == `PSD_ADDR_MODE;
  wire [2:0] md = reg_rdata_out[2:0];
  wire en = synth_enabled_out;
  wire lpd = low_band_pulldown_out;
  wire hpd = high_band_pulldown_out;
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  chk_ref_off:
    assert property (rwr && dis |=> !en) else $error("ref off");
  chk_ref_on:
    assert property (rwr && !dis && !rld |=> en) else $error("ref on");
  chk_off_pulled:
    assert property (!en |-> lpd && hpd) else $error("pins off");
  chk_off_float:
    assert property (!en [*2] |-> !error_output_a_oe_out &&
      !error_output_b_oe_out) else $error("pump off");
  chk_reload_off:
    assert property (rld |=> !en) else $error("reload");
  chk_halt_keep:
    assert property (halt_in && !rld |=> $stable(en)) else $error("halt");
  chk_mode_off:
    assert property (msel && md == `PSD_MODE_OFF |-> lpd && hpd)
      else $error("mode off");
  chk_low_band:
    assert property (msel && en && (md == `PSD_MODE_DIRECT ||
      md == `PSD_MODE_SW_LOW) |-> !lpd && hpd) else $error("low band");
  chk_high_band:
    assert property (msel && en && md == `PSD_MODE_SW_HIGH |-> lpd && !hpd)
      else $error("high band");
endmodule // psd_ctrl_chk
bind psd_ctrl psd_ctrl_chk chk
(
  .sys_clk_in, .rstn_in, .wdt_stack_reset_in, .clock_stop_in, .halt_in,
  .reg_addr_in, .reg_wdata_in, .reg_write_in, .reg_rdata_out,
  .low_band_pulldown_out, .high_band_pulldown_out, .error_output_a_oe_out,
  .error_output_b_oe_out, .synth_enabled_out
);
`default_nettype wire

// ===== verification/psd_ctrl_test.sv
// Self-checking bench of the synthesizer divider control
`timescale 1ns/10ps
`default_nettype none
`include "psd_defs.vh"
module psd_ctrl_test;
  localparam logic [11:0] TBL = 12'hd6f;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wdt = 1'b0;
  logic cstop = 1'b0;
  logic halt = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] got;
  wire [15:0] rdata;
  wire lo, hi, lpd, hpd, ea, ea_oe, eb, eb_oe, en, psh;
  int n_errors = 0;
  int num_checks = 0;
  always #2 clk = ~clk;
  psd_ctrl dut
  (
    .sys_clk_in(clk), .rstn_in(rstn), .wdt_stack_reset_in(wdt),
    .clock_stop_in(cstop), .halt_in(halt), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
    .reg_rdata_out(rdata), .low_band_osc_input_in(lo),
    .high_band_osc_input_in(hi), .low_band_pulldown_out(lpd),
    .high_band_pulldown_out(hpd), .error_output_a_out(ea),
    .error_output_a_oe_out(ea_oe), .error_output_b_out(eb),
    .error_output_b_oe_out(eb_oe), .synth_enabled_out(en),
    .prescaler_high_out(psh)
  );
  psd_vco_model vco
  (
    .low_pd_in(lpd), .high_pd_in(hpd), .low_out(lo), .high_out(hi)
  );
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic pins(input logic [2:0] e);
    @(posedge clk);
    #1 chk({13'h0000, en, lpd, hpd}, {13'h0000, e});
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] e, m);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    #1 got = rdata;
    @(posedge clk);
    rd <= 1'b0;
    chk(got & m, e);
  endtask
  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Three bounded waits of 4000 cycles each plus the register traffic
  initial
  begin
    #100000;
    n_errors++;
    results();
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    pins(3'h3);
    reg_rd(`PSD_ADDR_REF, 16'h0007, 16'hffff);
    reg_rd(`PSD_ADDR_UNLOCK, 16'h0000, 16'hfffe);
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(`PSD_ADDR_REF, 16'h0008 | c[15:0]);
      reg_rd(`PSD_ADDR_REF, c[15:0], 16'hffff);
      pins({c < 6, 2'h3});
    end
    $display("test reference done");
    reg_wr(`PSD_ADDR_REF, 16'h0001);
    for (int m = 0; m < 4; m++)
    begin
      reg_wr(`PSD_ADDR_MODE, m[15:0]);
      pins(TBL[3 * m +: 3]);
    end
    reg_wr(`PSD_ADDR_REF, 16'h0006);
    pins(3'h3);
    $display("test mode done");
    reg_wr(`PSD_ADDR_REF, 16'h0001);
    @(posedge clk);
    halt <= 1'b1;
    reg_wr(`PSD_ADDR_REF, 16'h0007);
    reg_rd(`PSD_ADDR_REF, 16'h0001, 16'hffff);
    halt <= 1'b0;
    @(posedge clk);
    wdt <= 1'b1;
    @(posedge clk);
    wdt <= 1'b0;
    reg_rd(`PSD_ADDR_REF, 16'h0007, 16'hffff);
    reg_wr(`PSD_ADDR_REF, 16'h0001);
    @(posedge clk);
    cstop <= 1'b1;
    @(posedge clk);
    cstop <= 1'b0;
    reg_rd(`PSD_ADDR_REF, 16'h0007, 16'hffff);
    $display("test hold done");
    reg_wr(`PSD_ADDR_MODE, 16'h0000);
    reg_wr(`PSD_ADDR_REF, 16'h0005);
    addr <= `PSD_ADDR_UNLOCK;
    #1;
    for (int k = 0; k < 4000 && !(ea_oe === 1'b1 && rdata[0] === 1'b1); k++)
      #4;
    chk({13'h0000, ea_oe, ea, eb}, 16'h0004);
    reg_rd(`PSD_ADDR_UNLOCK, 16'h0001, 16'hffff);
    reg_wr(`PSD_ADDR_REF, 16'h0007);
    reg_rd(`PSD_ADDR_UNLOCK, 16'h0000, 16'hfffe);
    reg_rd(`PSD_ADDR_UNLOCK, 16'h0000, 16'hffff);
    reg_wr(`PSD_ADDR_MODE, 16'h0001);
    reg_wr(`PSD_ADDR_DATA, 16'h0010);
    reg_wr(`PSD_ADDR_REF, 16'h0005);
    #1;
    for (int k = 0; k < 4000 && ea !== 1'b1; k++)
      #4;
    chk({13'h0000, ea_oe, ea, eb}, 16'h0007);
    $display("test pump done");
    reg_wr(`PSD_ADDR_MODE, 16'h000a);
    reg_wr(`PSD_ADDR_DATA, 16'h0a23);
    reg_rd(`PSD_ADDR_DATA, 16'h0a23, 16'hffff);
    reg_rd(`PSD_ADDR_MODE, 16'h000a, 16'h000f);
    #1;
    for (int k = 0; k < 4000 && psh !== 1'b1; k++)
      #4;
    chk({15'h0000, psh}, 16'h0001);
    $display("test swallow done");
    results();
  end
endmodule // psd_ctrl_test
`default_nettype wire

// ===== verification/psd_vco_model.sv
// Oscillator model driving both band inputs of the synthesizer
`timescale 1ns/10ps
`default_nettype none
module psd_vco_model
#(
  parameter int HALF_NS = 5
)
(
  // Pull-down requests from the device
  input wire logic low_pd_in,
  input wire logic high_pd_in,
  // Oscillator pins
  output logic low_out,
  output logic high_out
);
  logic osc = 1'b0;
  // Free running and unrelated in phase to the system clock
  always #(HALF_NS) osc = ~osc;
  // A pulled-down pin rests at ground, never at its last level
  assign low_out = low_pd_in ? 1'b0 : osc;
  assign high_out = high_pd_in ? 1'b0 : osc;
endmodule // psd_vco_model
`default_nettype wire
